// [hdl/nand_host.sv]
// APB-controlled host that drives a NAND flash over its command/address/data pins
//
// Our own choices: register access over APB and the register offsets.

module nand_host (
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             CHIP_SEL_N_O,
  output logic             CMD_LATCH_O,
  output logic             ADDR_LATCH_O,
  output logic             WRITE_STROBE_N_O,
  output logic             READ_STROBE_N_O,
  output logic             WRITE_GUARD_N_O,
  output logic             SPARE_SKIP_O,
  output logic      [7:0]  SHARED_BYTE_BUS_O,
  output logic             SHARED_BYTE_BUS_OE_O,
  input  wire logic [7:0]  SHARED_BYTE_BUS_I,
  input  wire logic        READY_I
);
  logic [1:0]               rst_q;
  logic                     rst_n;
  logic [3:0]               div;
  nand_host_pkg::st_e       state;
  nand_host_pkg::st_e       next_state;
  logic [2:0]               idx;
  logic [2:0]               next_idx;
  logic [3:0]               cnt;
  logic [3:0]               next_cnt;
  logic [3:0]               op;
  logic                     direct;
  nand_host_pkg::kind_e     dkind;
  logic [7:0]               wbyte;
  logic [7:0]               rbyte;
  logic [7:0]               last_cmd;
  logic [2:0]               cfg;
  logic [23:0]              addr;
  logic                     err;
  logic [14:0]              last_page;
  logic [1:0]               main_cnt;
  logic [1:0]               spare_cnt;
  logic [2:0]               adr_seen;
  nand_host_pkg::step_s     cur;

  // Reset release through two flops
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  sync_if #(.W(9)) pins ();
  assign pins.raw = {READY_I, SHARED_BYTE_BUS_I};
  pin_sync #(.W(9)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .s       (pins.filt)
  );
  wire       rb_ok  = pins.clean[8];
  wire [7:0] bus_in = pins.clean[7:0];

  // Step divider: all pin phases are whole steps
  wire tick = div == nand_host_pkg::STEP_LAST;
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) div <= 4'h0;
    else div <= tick ? 4'h0 : div + 4'h1;
  end

  // Address bytes: half select travels in the read command, not an address cycle
  wire [7:0] col = addr[7:0];
  wire [7:0] rlo = addr[nand_host_pkg::ROW_LSB +: 8];
  wire [7:0] rhi = {1'b0, addr[nand_host_pkg::ROW_LSB + 8 +: 7]};
  wire       a8  = addr[nand_host_pkg::HALF_BIT];

  function automatic nand_host_pkg::step_s mk(input nand_host_pkg::kind_e k,
                                               input logic [7:0] d, input logic l);
    nand_host_pkg::step_s s;
    s.kind = k;
    s.data = d;
    s.last = l;
    return s;
  endfunction

  function automatic nand_host_pkg::step_s adr(input logic [2:0] j, input logic fin);
    return mk(nand_host_pkg::K_ADR, (j == 3'h0) ? col : (j == 3'h1) ? rlo : rhi,
              fin & (j == 3'h2));
  endfunction

  // Byte sequence of each operation
  function automatic nand_host_pkg::step_s seq(input logic [3:0] o, input logic [2:0] i);
    nand_host_pkg::step_s s;
    logic                 first;
    first = i == 3'h0;
    s = mk(nand_host_pkg::K_CMD, nand_host_pkg::CMD_RESET, 1'b1);
    case (o)
      nand_host_pkg::OP_READ_MAIN:  s = first ? mk(nand_host_pkg::K_CMD,
          a8 ? nand_host_pkg::CMD_READ_HI : nand_host_pkg::CMD_READ_LO, 1'b0)
          : adr(i - 3'h1, 1'b1);
      nand_host_pkg::OP_READ_SPARE: s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_SPARE, 1'b0) : adr(i - 3'h1, 1'b1);
      nand_host_pkg::OP_IDENTITY_READ_CMD:    s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_IDENT, 1'b0) : mk(nand_host_pkg::K_ADR, 8'h00, 1'b1);
      nand_host_pkg::OP_PROG_MAIN:  s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_PROG, 1'b0) : adr(i - 3'h1, 1'b1);
      nand_host_pkg::OP_PROG_SPARE: s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_SPARE, 1'b0) : (i == 3'h1) ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_PROG, 1'b0) : adr(i - 3'h2, 1'b1);
      nand_host_pkg::OP_PROG_GO:    s = mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_PROG_GO, 1'b1);
      nand_host_pkg::OP_ERASE:      s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_ERASE, 1'b0) : (i == 3'h3) ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_ERASE_GO, 1'b1) : adr(i, 1'b0);
      nand_host_pkg::OP_STATUS:     s = first ? mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_STATUS, 1'b0) : mk(nand_host_pkg::K_RD, 8'h00, 1'b1);
      default:                      s = mk(nand_host_pkg::K_CMD,
          nand_host_pkg::CMD_RESET, 1'b1);
    endcase
    return s;
  endfunction

  assign cur = direct ? mk(dkind, wbyte, 1'b1) : seq(op, idx);

  // APB decode
  wire acc    = PSEL_I & PENABLE_I & ~PREADY_O;
  wire take   = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  wire a_ctrl = PADDR_I == nand_host_pkg::OFS_CTRL;
  wire a_cfg  = PADDR_I == nand_host_pkg::OFS_CFG;
  wire a_addr = PADDR_I == nand_host_pkg::OFS_ADDR;
  wire a_data = PADDR_I == nand_host_pkg::OFS_DATA;
  wire a_stat = PADDR_I == nand_host_pkg::OFS_STAT;
  wire mapped = a_ctrl | a_cfg | a_addr | a_data | a_stat;
  wire idle   = state == nand_host_pkg::S_IDLE;

  wire [3:0]  op_new    = PWDATA_I[3:0];
  wire        legal     = op_new <= 4'(nand_host_pkg::OP_STATUS);
  wire        is_pm     = op_new == 4'(nand_host_pkg::OP_PROG_MAIN);
  wire        is_ps     = op_new == 4'(nand_host_pkg::OP_PROG_SPARE);
  wire        is_go     = op_new == 4'(nand_host_pkg::OP_PROG_GO);
  wire        is_er     = op_new == 4'(nand_host_pkg::OP_ERASE);
  wire [14:0] page_new  = addr[23:nand_host_pkg::ROW_LSB];
  wire        same_page = page_new == last_page;
  wire        over      = same_page & ((is_pm & (main_cnt == nand_host_pkg::PROG_MAIN_MAX))
                        | (is_ps & (spare_cnt == nand_host_pkg::PROG_SPARE_MAX)));
  // Confirm without a pending setup would be a lone second cycle
  wire        unpaired  = is_go & (last_cmd != nand_host_pkg::CMD_PROG);
  wire        go_req    = take & a_ctrl;
  wire        go        = go_req & idle & legal & ~over & ~unpaired;
  wire        refuse    = go_req & ~go;
  wire        dgo       = acc & a_data & idle;
  wire        need_rdy  = direct | ~((op == 4'(nand_host_pkg::OP_RESET))
                        | (op == 4'(nand_host_pkg::OP_STATUS)));
  wire        strobe_end = tick & (state == nand_host_pkg::S_LOW)
                         & (next_state == nand_host_pkg::S_HIGH);
  wire        data_done = tick & (state == nand_host_pkg::S_HIGH) & direct & cur.last;
  wire [31:0] rd_word   = a_ctrl ? 32'(op) : a_cfg ? 32'(cfg) : a_addr ? 32'(addr)
                        : a_data ? 32'(rbyte)
                        : a_stat ? 32'({rbyte, 5'h00, err, rb_ok, ~idle}) : 32'h0000_0000;

  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_cnt   = cnt;
    case (state)
      nand_host_pkg::S_IDLE: if (go | dgo) begin
        next_state = nand_host_pkg::S_WAIT;
        next_idx   = 3'h0;
      end
      nand_host_pkg::S_WAIT: if (tick & (rb_ok | ~need_rdy)) begin
        next_state = nand_host_pkg::S_SETUP;
        next_cnt   = 4'h0;
      end
      nand_host_pkg::S_SETUP: if (tick) next_state = nand_host_pkg::S_LOW;
      nand_host_pkg::S_LOW: if (tick) begin
        if ((cur.kind == nand_host_pkg::K_RD) & (cnt != nand_host_pkg::RD_LAST))
          next_cnt = cnt + 4'h1;
        else next_state = nand_host_pkg::S_HIGH;
      end
      nand_host_pkg::S_HIGH: if (tick) begin
        if (!cur.last) begin
          next_state = nand_host_pkg::S_WAIT;
          next_idx   = idx + 3'h1;
        end else if (direct) begin
          next_state = nand_host_pkg::S_IDLE;
        end else begin
          // Hold off the next ready check until busy can show
          next_state = nand_host_pkg::S_GAP;
          next_cnt   = 4'h0;
        end
      end
      nand_host_pkg::S_GAP: if (tick) begin
        if (cnt == nand_host_pkg::GAP_LAST) next_state = nand_host_pkg::S_IDLE;
        else next_cnt = cnt + 4'h1;
      end
      default: next_state = nand_host_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state    <= nand_host_pkg::S_IDLE;
      idx      <= 3'h0;
      cnt      <= 4'h0;
      rbyte    <= 8'h00;
      last_cmd <= 8'h00;
      adr_seen <= 3'h0;
    end else begin
      state <= next_state;
      idx   <= next_idx;
      cnt   <= next_cnt;
      if (strobe_end & (cur.kind == nand_host_pkg::K_RD)) rbyte <= bus_in;
      if (strobe_end & (cur.kind == nand_host_pkg::K_CMD)) last_cmd <= cur.data;
      if (idle) adr_seen <= 3'h0;
      else if (strobe_end & (cur.kind == nand_host_pkg::K_ADR)) adr_seen <= adr_seen + 3'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg    <= nand_host_pkg::CFG_RST;
      addr   <= 24'h00_0000;
      op     <= 4'h0;
      direct <= 1'b0;
      dkind  <= nand_host_pkg::K_WR;
      wbyte  <= 8'h00;
      err    <= 1'b0;
    end else begin
      if (take & a_cfg) cfg <= PWDATA_I[2:0];
      if (take & a_addr) addr <= PWDATA_I[23:0];
      if (go) begin
        op     <= op_new;
        direct <= 1'b0;
      end else if (dgo) begin
        direct <= 1'b1;
        dkind  <= PWRITE_I ? nand_host_pkg::K_WR : nand_host_pkg::K_RD;
        wbyte  <= PWDATA_I[7:0];
      end
      // A refusal in the clearing cycle still leaves the flag set
      if (refuse) err <= 1'b1;
      else if (take & a_stat & PWDATA_I[nand_host_pkg::ST_ERR_BIT]) err <= 1'b0;
    end
  end

  // Only the most recent page is tracked, so interleaving pages escapes the cap
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      last_page <= 15'h0000;
      main_cnt  <= 2'h0;
      spare_cnt <= 2'h0;
    end else if (go & (is_pm | is_ps)) begin
      last_page <= page_new;
      main_cnt  <= (same_page ? main_cnt : 2'h0) + {1'b0, is_pm};
      spare_cnt <= (same_page ? spare_cnt : 2'h0) + {1'b0, is_ps};
    end else if (go & is_er & (addr[23:nand_host_pkg::BLK_LSB]
                 == last_page[14:nand_host_pkg::BLK_LSB - nand_host_pkg::ROW_LSB])) begin
      main_cnt  <= 2'h0;
      spare_cnt <= 2'h0;
    end
  end

  wire pins_on = (next_state == nand_host_pkg::S_SETUP) | (next_state == nand_host_pkg::S_LOW)
               | (next_state == nand_host_pkg::S_HIGH);
  wire low_ph  = next_state == nand_host_pkg::S_LOW;
  wire rd_kind = cur.kind == nand_host_pkg::K_RD;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CHIP_SEL_N_O         <= 1'b1;
      CMD_LATCH_O          <= 1'b0;
      ADDR_LATCH_O         <= 1'b0;
      WRITE_STROBE_N_O     <= 1'b1;
      READ_STROBE_N_O      <= 1'b1;
      WRITE_GUARD_N_O      <= 1'b0;
      SPARE_SKIP_O         <= 1'b0;
      SHARED_BYTE_BUS_O    <= 8'h00;
      SHARED_BYTE_BUS_OE_O <= 1'b0;
    end else begin
      // Chip select falls a step before any strobe and rises after the last, unless the CFG_SEL_BIT hold is set
      CHIP_SEL_N_O         <= ~(cfg[nand_host_pkg::CFG_SEL_BIT]
                            | (next_state != nand_host_pkg::S_IDLE));
      CMD_LATCH_O          <= pins_on & (cur.kind == nand_host_pkg::K_CMD);
      ADDR_LATCH_O         <= pins_on & (cur.kind == nand_host_pkg::K_ADR);
      WRITE_STROBE_N_O     <= ~(low_ph & ~rd_kind);
      READ_STROBE_N_O      <= ~(low_ph & rd_kind);
      WRITE_GUARD_N_O      <= cfg[nand_host_pkg::CFG_GUARD_BIT];
      SPARE_SKIP_O         <= cfg[nand_host_pkg::CFG_SKIP_BIT];
      SHARED_BYTE_BUS_O    <= cur.data;
      SHARED_BYTE_BUS_OE_O <= pins_on & ~rd_kind;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= acc & (~a_data | data_done);
      if (acc) begin
        PRDATA_O  <= rd_word;
        PSLVERR_O <= ~mapped;
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  strobe_select_a: assert property (
    !WRITE_STROBE_N_O |-> !CHIP_SEL_N_O) else $error("write strobe without chip select");
  strobe_width_a: assert property (
    $fell(WRITE_STROBE_N_O) |-> (!WRITE_STROBE_N_O)[*3] ##1 WRITE_STROBE_N_O)
    else $error("write strobe low time wrong");
  legal_code_a: assert property (
    (CMD_LATCH_O && !WRITE_STROBE_N_O) |-> SHARED_BYTE_BUS_O inside
    {8'h00, 8'h01, 8'h50, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70})
    else $error("undefined command code driven");
  ready_gate_a: assert property (
    (CMD_LATCH_O && !WRITE_STROBE_N_O && SHARED_BYTE_BUS_O != nand_host_pkg::CMD_RESET
     && SHARED_BYTE_BUS_O != nand_host_pkg::CMD_STATUS) |-> rb_ok)
    else $error("command issued while device busy");
  latch_excl_a: assert property (
    !(CMD_LATCH_O && ADDR_LATCH_O)) else $error("both latch strobes high");
  three_addr_a: assert property (
    (data_done == 1'b0 && state == nand_host_pkg::S_HIGH && next_state == nand_host_pkg::S_GAP
     && (op == 4'(nand_host_pkg::OP_READ_MAIN) || op == 4'(nand_host_pkg::OP_PROG_MAIN)))
    |-> adr_seen == 3'h3) else $error("page access without three address cycles");
  erase_addr_a: assert property (
    (state == nand_host_pkg::S_HIGH && next_state == nand_host_pkg::S_GAP
     && op == 4'(nand_host_pkg::OP_ERASE)) |-> adr_seen == 3'h2)
    else $error("erase without exactly two row cycles");
  confirm_pair_a: assert property (
    (CMD_LATCH_O && $fell(WRITE_STROBE_N_O) && SHARED_BYTE_BUS_O inside {8'h10, 8'hD0})
    |-> last_cmd == ((SHARED_BYTE_BUS_O == 8'hD0) ? 8'h60 : 8'h80))
    else $error("confirm code without its setup code");
  ident_code_a: assert property (
    (state == nand_host_pkg::S_WAIT && next_state == nand_host_pkg::S_SETUP && !direct
     && idx == 3'h0 && op == 4'(nand_host_pkg::OP_IDENTITY_READ_CMD))
    |=> CMD_LATCH_O && SHARED_BYTE_BUS_O == 8'h90) else $error("identity read code wrong");
  prog_cap_a: assert property (
    main_cnt <= nand_host_pkg::PROG_MAIN_MAX) else $error("main area program cap passed");

  prog_go_c:  cover property (CMD_LATCH_O && SHARED_BYTE_BUS_O == 8'h10);
  erase_go_c: cover property (CMD_LATCH_O && SHARED_BYTE_BUS_O == 8'hD0);
  data_rd_c:  cover property (data_done && dkind == nand_host_pkg::K_RD);
  refuse_c:   cover property (refuse);
endmodule

// [hdl/nand_host_pkg.sv]
// Constants, codes and types shared by the flash host controller
package nand_host_pkg;
  // Pin timing: every strobe phase lasts one step, except read strobe low, which lasts three
  localparam int         CLK_NS      = 10;
  localparam int         STEP_NS     = 30;
  localparam int         STEP_CYC    = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STEP_LAST   = 4'(STEP_CYC - 1);
  // Read strobe low time covers read_access_delay plus the input synchroniser
  localparam int         RD_LOW_NS   = 90;
  localparam logic [3:0] RD_LAST     = 4'((RD_LOW_NS + STEP_NS - 1) / STEP_NS - 1);
  // Lag from the last write strobe until busy is visible on the ready pin
  localparam int         BUSY_LAG_NS = 150;
  localparam logic [3:0] GAP_LAST    = 4'((BUSY_LAG_NS + STEP_NS - 1) / STEP_NS - 1);

  // APB register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CFG  = 12'h004;
  localparam logic [11:0] OFS_ADDR = 12'h008;
  localparam logic [11:0] OFS_DATA = 12'h00C;
  localparam logic [11:0] OFS_STAT = 12'h010;

  // Field positions and reset values
  localparam int         CFG_GUARD_BIT = 0;
  localparam int         CFG_SKIP_BIT  = 1;
  localparam int         CFG_SEL_BIT   = 2;
  localparam logic [2:0] CFG_RST       = 3'h0;
  localparam int         ST_ERR_BIT    = 2;
  localparam int         HALF_BIT      = 8;
  localparam int         ROW_LSB       = 9;
  localparam int         BLK_LSB       = 14;

  // Command codes
  localparam logic [7:0] CMD_READ_LO  = 8'h00;
  localparam logic [7:0] CMD_READ_HI  = 8'h01;
  localparam logic [7:0] CMD_SPARE    = 8'h50;
  localparam logic [7:0] CMD_IDENT    = 8'h90;
  localparam logic [7:0] CMD_RESET    = 8'hFF;
  localparam logic [7:0] CMD_PROG     = 8'h80;
  localparam logic [7:0] CMD_PROG_GO  = 8'h10;
  localparam logic [7:0] CMD_ERASE    = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS   = 8'h70;

  // Program passes allowed on one page between erases
  localparam logic [1:0] PROG_MAIN_MAX  = 2'h2;
  localparam logic [1:0] PROG_SPARE_MAX = 2'h3;

  typedef enum logic [3:0] {
    OP_READ_MAIN, OP_READ_SPARE, OP_IDENTITY_READ_CMD, OP_RESET, OP_PROG_MAIN,
    OP_PROG_SPARE, OP_PROG_GO, OP_ERASE, OP_STATUS
  } op_e;
  typedef enum logic [1:0] {K_CMD, K_ADR, K_WR, K_RD} kind_e;
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_SETUP, S_LOW, S_HIGH, S_GAP} st_e;
  typedef struct packed {
    logic       last;
    kind_e      kind;
    logic [7:0] data;
  } step_s;
endpackage

// [hdl/pin_sync.sv]
// Three-stage pin synchroniser, a bit changes once stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  sync_if.filt      s
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] clean;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      clean <= '0;
    end else begin
      s1    <= s.raw;
      s2    <= s1;
      s3    <= s2;
      clean <= (s2 & s3) | (clean & (s2 | s3));
    end
  end

  assign s.clean = clean;
endmodule

// [hdl/sync_if.sv]
// Raw and filtered views of asynchronous pin inputs
interface sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// [verification/nand_dev_model.sv]
// Behavioural flash device on the far side of the host's pins
module nand_dev_model #(
  parameter logic [7:0] ID_CODE = 8'h3C  // Arbitrary identity value
) (
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic       wp_n_i,
  input  wire logic       spare_skip_i,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic            rb_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cmd   = 8'h00;
  logic [7:0]  dq    = 8'h00;
  logic [9:0]  col   = 10'h000;
  logic [14:0] row   = 15'h0000;
  logic [9:0]  blk   = 10'h000;
  logic [1:0]  ptr   = 2'h0;
  logic [1:0]  acnt  = 2'h0;
  logic        busy  = 1'b0;
  int          n_prog = 0;
  int          bt    = 0;
  logic [7:0]  mem  [int];
  logic [7:0]  pend [int];
  event        go;
  wire  [1:0]  need = (cmd == 8'h60) ? 2'd2 : (cmd == 8'h90) ? 2'd1 : 2'd3;
  assign rb_low_o = busy;
  // Released bus shows the inverse of the last byte, not a lucky match
  assign dq_o = (!ce_n_i && !re_n_i) ? dq : ~dq;
  // Busy runs to its end whatever chip select does
  always @(go) begin
    busy = 1'b1;
    #(bt) busy = 1'b0;
  end
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i && (!busy || dq_i inside {8'hFF, 8'h70})) begin
      acnt = 0;
      if (ptr == 2'h1 && !(dq_i inside {8'h00, 8'h01})) ptr = 2'h0;
      case (dq_i)
        8'h00, 8'h01: ptr = dq_i[1:0];
        8'h50: ptr = 2'h2;
        8'h80: pend.delete();
        8'h10: if (wp_n_i) begin
          foreach (pend[k]) mem[k] = pend[k];
          n_prog++;
          bt = 3000;
          ->go;
        end
        8'hD0: if (wp_n_i) begin
          blk = row[14:5];
          bt = 5000;
          ->go;
        end
        8'hFF: begin
          ptr = 2'h0;
          bt = 200;
          ->go;
        end
        default: ;
      endcase
      cmd = dq_i;
    end else if (ale_i && acnt < need) begin
      if (acnt == 0 && cmd != 8'h60) col = (ptr == 2) ? 10'(512 + dq_i[3:0]) : {1'b0, ptr[0], dq_i};
      else if (acnt == need - 2) row[7:0] = dq_i;
      else row[14:8] = dq_i[6:0];
      acnt++;
      if (acnt == 3 && cmd inside {8'h00, 8'h01, 8'h50}) begin
        bt = 500;
        ->go;
      end
    end else if (!cle_i && !ale_i && !busy) begin
      pend[{row, col}] = dq_i;
      col++;
    end
  end
  always @(negedge re_n_i) if (!ce_n_i) begin
    if (cmd == 8'h70) dq = {wp_n_i, !busy, 6'h00};
    else if (cmd == 8'h90) dq = ID_CODE;
    else dq = mem.exists({row, col}) ? mem[{row, col}] : (col[7:0] ^ row[7:0] ^ 8'hA5);
    col++;
    if (col == 10'd512 && spare_skip_i) col = 10'd0;
  end
endmodule

// [verification/nand_host_tb.sv]
// Self-checking bench: APB driver, result queue and flash model
module nand_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
  localparam logic [7:0] ID = 8'h3C;
  logic        clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic        prdy, perr, cs_n, cle, ale, we_n, re_n, wp_n, skip, oe, rb_low;
  logic [7:0]  bo, dq, lvl, v, c;
  logic [14:0] pg;
  int          n_errors = 0, checks_done = 0, seed = 61;
  exp_s        q[$];
  always #5 clk = ~clk;
  assign lvl = oe ? bo : dq;
  nand_host dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .CHIP_SEL_N_O(cs_n), .CMD_LATCH_O(cle), .ADDR_LATCH_O(ale),
    .WRITE_STROBE_N_O(we_n), .READ_STROBE_N_O(re_n), .WRITE_GUARD_N_O(wp_n),
    .SPARE_SKIP_O(skip), .SHARED_BYTE_BUS_O(bo), .SHARED_BYTE_BUS_OE_O(oe),
    .SHARED_BYTE_BUS_I(lvl), .READY_I(!rb_low));
  nand_dev_model #(.ID_CODE(ID)) dev (.ce_n_i(cs_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .spare_skip_i(skip), .dq_i(lvl),
    .dq_o(dq), .rb_low_o(rb_low));
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_apb(input exp_s e);
    checks_done++;
    if ((prd & e.m) !== (e.d & e.m) || perr !== e.e) begin
      n_errors++;
      $display("unexpected apb answer %h err %b at %0t", prd, perr, $time);
    end
  endtask
  task automatic cmp_pin(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected pin state %h want %h at %0t", g, x, $time);
    end
  endtask
  always @(posedge clk) if (psel && pen && prdy === 1'b1) cmp_apb(q.pop_front());
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, m,
                      input logic e);
    q.push_back('{d: d, m: m, e: e});
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    r = prd;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1, a, d, 0, 0);
  endtask
  task automatic op(input logic [3:0] k);
    wr(nand_host_pkg::OFS_CTRL, {28'h0, k});
    do begin
      xfer(0, nand_host_pkg::OFS_STAT, 0, 0, 0);
    end while (r[1:0] !== 2'b10);
  endtask
  task automatic prog(input logic [14:0] p);
    wr(nand_host_pkg::OFS_ADDR, {8'h0, p, 1'b0, c});
    op(4);
    wr(nand_host_pkg::OFS_DATA, {24'h0, v});
    op(6);
  endtask
  function automatic logic [7:0] pat(input logic [14:0] p, input logic [9:0] cc);
    return cc[7:0] ^ p[7:0] ^ 8'hA5;
  endfunction
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1;
    repeat (6) @(posedge clk);
    pg = 15'($random(seed));
    v = 8'($random(seed));
    c = 8'($random(seed));
    xfer(0, nand_host_pkg::OFS_CFG, 0, 32'h0000_0007, 0);
    xfer(0, 12'h020, 0, 32'hFFFF_FFFF, 1);
    op(3);
    cmp_pin(dev.cmd, 8'hFF);
    op(8);
    xfer(0, nand_host_pkg::OFS_STAT, 32'h0000_4000, 32'h0000_FF00, 0);
    op(2);
    xfer(0, nand_host_pkg::OFS_DATA, ID, 32'h0000_00FF, 0);
    prog(pg ^ 15'h0001);
    cmp_pin(dev.n_prog, 0);
    wr(nand_host_pkg::OFS_CFG, 32'h0000_0001);
    // Third pass on the same page must be refused by the host
    for (int i = 0; i < 3; i++) prog(pg);
    cmp_pin(dev.n_prog, 2);
    xfer(0, nand_host_pkg::OFS_STAT, 32'h0000_0004, 32'h0000_0004, 0);
    wr(nand_host_pkg::OFS_STAT, 32'h0000_0004);
    xfer(0, nand_host_pkg::OFS_STAT, 0, 32'h0000_0004, 0);
    op(0);
    xfer(0, nand_host_pkg::OFS_DATA, {24'h0, v}, 32'h0000_00FF, 0);
    xfer(0, nand_host_pkg::OFS_DATA, pat(pg, 10'(c) + 1), 32'h0000_00FF, 0);
    wr(nand_host_pkg::OFS_ADDR, {8'h0, pg, 1'b1, c});
    op(0);
    xfer(0, nand_host_pkg::OFS_DATA, pat(pg, {2'b01, c}), 32'h0000_00FF, 0);
    op(8);
    cmp_pin(dev.ptr, 0);
    op(1);
    xfer(0, nand_host_pkg::OFS_DATA, pat(pg, 10'(512 + c[3:0])), 32'h0000_00FF, 0);
    // Chip select held low too; the pins follow the register one edge later
    wr(nand_host_pkg::OFS_CFG, 32'h0000_0007);
    repeat (2) @(posedge clk);
    cmp_pin(skip, 1);
    cmp_pin(cs_n, 0);
    op(7);
    cmp_pin(dev.blk, pg[14:5]);
    // Spare program after the erase cleared the page's pass count
    op(5);
    wr(nand_host_pkg::OFS_DATA, {24'h0, v});
    op(6);
    op(1);
    xfer(0, nand_host_pkg::OFS_DATA, {24'h0, v}, 32'h0000_00FF, 0);
    end_of_test();
  end
endmodule
